// ==== lpc_slave_shutdown_error_flags_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// bench top: clock, reset, bus tasks and the test sequence
// ****************************************************************
module lpc_slave_shutdown_error_flags_tb;
  logic        mclk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lclk;
  logic        lresetN;
  logic        lpcpdN;
  logic        lframeN;
  logic        gateA20;
  logic        cycleBusy;
  logic        pmeOut;
  logic        pmeOe;
  logic        smiOut;
  logic        smiOe;
  logic        sciOut;
  logic        sciOe;
  logic        softShutdown;
  logic        errorIrq;
  logic        irq;
  logic [31:0] rdData;
  logic        lastErr;
  int          badCount;
  int          numChecks;
  int          cycles = 0;

  lssef_top dut_u (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lclk(lclk),
    .lresetN(lresetN), .lpcpdN(lpcpdN), .lframeN(lframeN), .gateA20(gateA20), .cycleBusy(cycleBusy),
    .pmeOut(pmeOut), .pmeOe(pmeOe), .smiOut(smiOut), .smiOe(smiOe), .sciOut(sciOut), .sciOe(sciOe),
    .softShutdown(softShutdown), .errorIrq(errorIrq), .irq(irq));

  lssef_lpc_host host_u (.lclk(lclk), .lresetN(lresetN), .lpcpdN(lpcpdN), .lframeN(lframeN),
    .gateA20(gateA20));

  // clock and hang guard
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount = badCount + 1;
      $display("ERROR at %0t: run did not finish in time", $time);
      endOfTest();
    end
  end

  // one bus transfer: setup, access held until pready is seen high
  task automatic apbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // ends once pready is seen high; the hang guard ends it if pready never rises
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rdData  = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apbXfer(1'b1, a, {24'h000000, d});
  endtask

  task automatic waitClk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // register read compared with an expected byte
  task automatic chkReg(input logic [7:0] a, input logic [7:0] e);
    apbXfer(1'b0, a, 32'h00000000);
    numChecks++;
    if (rdData !== {24'h000000, e}) begin
      badCount++;
      $display("ERROR at %0t: read %h got %h want %h", $time, a, rdData, e);
    end
  endtask

  // output levels compared with an expected byte
  task automatic chkVal(input logic [7:0] act, input logic [7:0] e);
    numChecks++;
    if (act !== e) begin
      badCount++;
      $display("ERROR at %0t: output %h want %h", $time, act, e);
    end
  endtask

  task automatic testDone(input string name);
    $display("test %s finished, mismatches so far %0d", name, badCount);
  endtask

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, cycleBusy} = '0;
    {badCount, numChecks} = '0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    chkReg(lssef_pkg::ADDR_CTRL_ONE, 8'h00);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h00);
    chkReg(lssef_pkg::ADDR_IRQ_STAT, 8'h00);
    chkReg(lssef_pkg::ADDR_IRQ_MASK, 8'h00);
    chkVal({2'h0, pmeOut, smiOut, sciOut, pmeOe, smiOe, sciOe}, 8'h00);
    apbXfer(1'b0, 8'h14, 32'h00000000);
    chkVal({7'h00, lastErr}, 8'h01);
    testDone("reset");
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h07);
    waitClk(2);
    chkVal({5'h00, pmeOe, smiOe, sciOe}, 8'h00);
    wr(lssef_pkg::ADDR_CTRL_ZERO, 8'h07);
    waitClk(2);
    chkVal({5'h00, pmeOe, smiOe, sciOe}, 8'h07);
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h05);
    waitClk(2);
    chkVal({5'h00, pmeOe, smiOe, sciOe}, 8'h05);
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h00);
    wr(lssef_pkg::ADDR_CTRL_ZERO, 8'h00);
    testDone("sideband");
    chkReg(lssef_pkg::ADDR_CTRL_ONE, 8'h00);
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h08);
    chkReg(lssef_pkg::ADDR_CTRL_ONE, 8'h08);
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h00);
    chkReg(lssef_pkg::ADDR_CTRL_ONE, 8'h00);
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h08);
    wr(lssef_pkg::ADDR_IRQ_MASK, 8'h07);
    chkReg(lssef_pkg::ADDR_IRQ_MASK, 8'h07);
    host_u.setPins(1'b0, 1'b1, 1'b0);
    waitClk(12);
    chkVal({7'h00, softShutdown}, 8'h00);
    host_u.setPins(1'b1, 1'b1, 1'b0);
    waitClk(12);
    chkVal({6'h00, irq, errorIrq}, 8'h02);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h40);
    wr(lssef_pkg::ADDR_CTRL_TWO, 8'h41);
    wr(lssef_pkg::ADDR_CTRL_TWO, 8'h01);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h41);
    chkVal({7'h00, errorIrq}, 8'h01);
    wr(lssef_pkg::ADDR_CTRL_TWO, 8'h01);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h01);
    chkVal({7'h00, errorIrq}, 8'h00);
    chkReg(lssef_pkg::ADDR_IRQ_STAT, 8'h01);
    chkReg(lssef_pkg::ADDR_IRQ_STAT, 8'h00);
    chkVal({7'h00, irq}, 8'h00);
    testDone("reset flag");
    chkReg(lssef_pkg::ADDR_CTRL_ONE, 8'h00);
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h08);
    host_u.setPins(1'b1, 1'b0, 1'b0);
    waitClk(12);
    chkVal({6'h00, softShutdown, errorIrq}, 8'h03);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h21);
    host_u.setPins(1'b1, 1'b1, 1'b0);
    waitClk(12);
    chkVal({7'h00, softShutdown}, 8'h00);
    wr(lssef_pkg::ADDR_CTRL_ZERO, 8'h10);
    wr(lssef_pkg::ADDR_CTRL_ZERO, 8'h00);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h01);
    wr(lssef_pkg::ADDR_CTRL_ZERO, 8'h08);
    chkReg(lssef_pkg::ADDR_CTRL_ONE, 8'h00);
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h08);
    host_u.setPins(1'b1, 1'b0, 1'b0);
    waitClk(12);
    chkVal({7'h00, softShutdown}, 8'h00);
    host_u.setPins(1'b1, 1'b1, 1'b0);
    wr(lssef_pkg::ADDR_CTRL_ZERO, 8'h00);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h21);
    wr(lssef_pkg::ADDR_CTRL_TWO, 8'h01);
    testDone("shutdown");
    host_u.abortFrame();
    waitClk(12);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h01);
    @(posedge mclk);
    cycleBusy <= 1'b1;
    host_u.abortFrame();
    waitClk(12);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h11);
    chkReg(lssef_pkg::ADDR_IRQ_STAT, 8'h06);
    cycleBusy <= 1'b0;
    chkReg(lssef_pkg::ADDR_CTRL_ONE, 8'h00);
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h08);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h01);
    wr(lssef_pkg::ADDR_CTRL_ONE, 8'h00);
    testDone("abort");
    host_u.setPins(1'b1, 1'b1, 1'b1);
    waitClk(12);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h81);
    wr(lssef_pkg::ADDR_CTRL_TWO, 8'h00);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h80);
    host_u.setPins(1'b1, 1'b1, 1'b0);
    waitClk(12);
    chkReg(lssef_pkg::ADDR_CTRL_TWO, 8'h00);
    testDone("monitor");
    endOfTest();
  end
endmodule
`default_nettype wire

// ==== lssef_lpc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host side of the link: clock, reset, power-down, frame, gate pins
// ****************************************************************
module lssef_lpc_host (
  output var logic lclk,
  output var logic lresetN,
  output var logic lpcpdN,
  output var logic lframeN,
  output var logic gateA20
);
  // idle levels; the clock stands still low between frames
  initial begin
    lclk    = 1'b0;
    lresetN = 1'b1;
    lpcpdN  = 1'b1;
    lframeN = 1'b1;
    gateA20 = 1'b0;
  end

  // frame start seen over two clock rises, then driven back high
  task automatic abortFrame();
    lframeN <= 1'b0;
    #20;
    repeat (2) begin
      lclk = 1'b1;
      #40;
      lclk = 1'b0;
      #40;
    end
    lframeN = 1'b1;
  endtask

  // static pin levels, changed with no relation to the local clock
  task automatic setPins(input logic rstN, input logic pdN, input logic gate_a20_monitor);
    lresetN <= rstN;
    lpcpdN  <= pdN;
    gateA20 <= gate_a20_monitor;
  endtask
endmodule
`default_nettype wire

// ==== lssef_pkg.sv ====
`default_nettype none
// ****************************************************************
// register map, field positions and reset values
// ****************************************************************
package lssef_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO  = 8'h04;
  localparam logic [7:0] ADDR_CTRL_ZERO = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;

  // host_interface_control_one fields
  localparam int unsigned C1_SOFT_SHUTDOWN_FLAG = 3;
  localparam int unsigned C1_PME_BIT   = 2;
  localparam int unsigned C1_SMI_BIT   = 1;
  localparam int unsigned C1_SCI_BIT   = 0;

  // host_interface_control_two fields
  localparam int unsigned C2_GATE_A20_MONITOR  = 7;
  localparam int unsigned C2_LPC_RESET_FLAG  = 6;
  localparam int unsigned C2_SHUTDOWN_FLAG  = 5;
  localparam int unsigned C2_ABORT_FLAG  = 4;
  localparam int unsigned C2_ERROR_INTERRUPT_ENABLE = 0;

  // host_interface_control_zero fields
  localparam int unsigned C0_SCI_EN   = 0;
  localparam int unsigned C0_SMI_EN   = 1;
  localparam int unsigned C0_PME_EN   = 2;
  localparam int unsigned C0_SHUTDOWN_PIN_ENABLE    = 3;
  localparam int unsigned C0_SOFT_RST = 4;
  localparam int unsigned C0_USED     = 5;

  // error event index, shared by flags and interrupt status
  localparam int unsigned EV_LPC_RESET_FLAG = 0;
  localparam int unsigned EV_SHUTDOWN_FLAG = 1;
  localparam int unsigned EV_ABORT_FLAG = 2;
  localparam int unsigned EV_W    = 3;

  // synchronised pin vector
  localparam int unsigned PIN_LRESET = 0;
  localparam int unsigned PIN_LPCPD  = 1;
  localparam int unsigned PIN_LFRAME = 2;
  localparam int unsigned PIN_LCLK   = 3;
  localparam int unsigned PIN_GATE_A20_MONITOR   = 4;
  localparam int unsigned PIN_W      = 5;
  localparam logic [4:0]  PIN_IDLE   = 5'h07;

  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [2:0]  EV_RESET   = 3'h0;
endpackage
`default_nettype wire

// ==== lssef_top.sv ====
// Operation
// - soft shutdown sets on 1 after reading 0
// - soft shutdown clears on 0, reset, shutdown
// - shutdown release without pin enable clears it
// - power event bit drives pin with enable
// - system management bit drives pin with enable
// - system control bit drives pin with enable
// - control two: interrupt bits, gate a20 monitor
// - monitors follow live pin levels always
// - reset flag sets on reset falling edge
// - reset flag clears on 0 after 1 read
// - shutdown flag sets on power-down falling edge
// - shutdown flag clears by write or reset
// - abort flag sets on frame fall mid-cycle
// - abort flag clears by write, reset, shutdown
// - flag positions accept only clearing zeros
// - error enable gates error interrupt
`timescale 1ns/1ps
`default_nettype none
module lssef_top (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lclk,
  input  wire logic        lresetN,
  input  wire logic        lpcpdN,
  input  wire logic        lframeN,
  input  wire logic        gateA20,
  input  wire logic        cycleBusy,
  output logic             pmeOut,
  output logic             pmeOe,
  output logic             smiOut,
  output logic             smiOe,
  output logic             sciOut,
  output logic             sciOe,
  output logic             softShutdown,
  output logic             errorIrq,
  output logic             irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic fallEdge(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic riseEdge(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  function automatic logic addrMapped(input logic [7:0] a);
    return (a == lssef_pkg::ADDR_CTRL_ONE) || (a == lssef_pkg::ADDR_CTRL_TWO) ||
           (a == lssef_pkg::ADDR_CTRL_ZERO) || (a == lssef_pkg::ADDR_IRQ_STAT) ||
           (a == lssef_pkg::ADDR_IRQ_MASK);
  endfunction

  function automatic int unsigned flagPos(input int unsigned ev);
    case (ev)
      lssef_pkg::EV_LPC_RESET_FLAG: return lssef_pkg::C2_LPC_RESET_FLAG;
      lssef_pkg::EV_SHUTDOWN_FLAG: return lssef_pkg::C2_SHUTDOWN_FLAG;
      default:            return lssef_pkg::C2_ABORT_FLAG;
    endcase
  endfunction

  // ****************************************************************
  // pin synchronisers and filters
  // ****************************************************************
  logic [4:0] pinsRaw;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [4:0] sync3_r;
  logic [4:0] filt_r;
  logic [4:0] filtPrev_r;
  logic [4:0] filt_nxt;

  assign pinsRaw = {gateA20, lclk, lframeN, lpcpdN, lresetN};

  // a bit changes only once stages two and three agree
  assign filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));

  // three-stage chain, first stage read only by the second
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r    <= lssef_pkg::PIN_IDLE;
      sync2_r    <= lssef_pkg::PIN_IDLE;
      sync3_r    <= lssef_pkg::PIN_IDLE;
      filt_r     <= lssef_pkg::PIN_IDLE;
      filtPrev_r <= lssef_pkg::PIN_IDLE;
    end else begin
      sync1_r    <= pinsRaw;
      sync2_r    <= sync1_r;
      sync3_r    <= sync2_r;
      filt_r     <= filt_nxt;
      filtPrev_r <= filt_r;
    end
  end

  // ****************************************************************
  // link events
  // ****************************************************************
  logic       lclkRise;
  logic       frameSmp_r;
  logic [2:0] ev;
  logic       pdRise;
  logic       hwReset;
  logic       lpcReset;
  logic       hwShutdown;
  logic       hwRelease;
  logic [7:0] ctrlZero_r;
  logic       softShutdown_r;

  assign lclkRise = riseEdge(filtPrev_r[lssef_pkg::PIN_LCLK], filt_r[lssef_pkg::PIN_LCLK]);

  // frame level as seen at each link clock rise, pulled back high while the frame is idle
  // so that a frame ended with the link clock stopped still arms the next fall
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      frameSmp_r <= 1'b1;
    end else if (lclkRise || filt_r[lssef_pkg::PIN_LFRAME]) begin
      frameSmp_r <= filt_r[lssef_pkg::PIN_LFRAME];
    end
  end

  // one-cycle event pulses from filtered samples
  assign ev[lssef_pkg::EV_LPC_RESET_FLAG] = fallEdge(filtPrev_r[lssef_pkg::PIN_LRESET],
                                           filt_r[lssef_pkg::PIN_LRESET]);
  assign ev[lssef_pkg::EV_SHUTDOWN_FLAG] = fallEdge(filtPrev_r[lssef_pkg::PIN_LPCPD],
                                           filt_r[lssef_pkg::PIN_LPCPD]);
  assign ev[lssef_pkg::EV_ABORT_FLAG] = lclkRise & cycleBusy &
                                  fallEdge(frameSmp_r, filt_r[lssef_pkg::PIN_LFRAME]);
  assign pdRise = riseEdge(filtPrev_r[lssef_pkg::PIN_LPCPD], filt_r[lssef_pkg::PIN_LPCPD]);

  // reset and shutdown conditions of the host interface
  assign hwReset    = ~filt_r[lssef_pkg::PIN_LRESET];
  assign lpcReset   = hwReset | ctrlZero_r[lssef_pkg::C0_SOFT_RST];
  assign hwShutdown = ~filt_r[lssef_pkg::PIN_LPCPD] & ctrlZero_r[lssef_pkg::C0_SHUTDOWN_PIN_ENABLE];
  assign hwRelease  = pdRise & ~ctrlZero_r[lssef_pkg::C0_SHUTDOWN_PIN_ENABLE];

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic        setupPh;
  logic        accessPh;
  logic        wrAcc;
  logic        rdAcc;
  logic        selOne;
  logic        selTwo;
  logic        selZero;
  logic        selStat;
  logic        selMask;
  logic [7:0]  rdByte;
  logic [31:0] prdata_r;
  logic [7:0]  ctrlOne;
  logic [7:0]  ctrlTwo;
  logic [2:0]  flag_r;
  logic [2:0] flag_nxt;
  logic        pmeBit_r;
  logic        smiBit_r;
  logic        sciBit_r;
  logic        error_interrupt_enable_r;
  logic [2:0]  irqStat_r;
  logic [2:0]  irqMask_r;

  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign wrAcc    = accessPh & pwrite & addrMapped(paddr);
  assign rdAcc    = accessPh & ~pwrite & addrMapped(paddr);
  assign selOne   = paddr == lssef_pkg::ADDR_CTRL_ONE;
  assign selTwo   = paddr == lssef_pkg::ADDR_CTRL_TWO;
  assign selZero  = paddr == lssef_pkg::ADDR_CTRL_ZERO;
  assign selStat  = paddr == lssef_pkg::ADDR_IRQ_STAT;
  assign selMask  = paddr == lssef_pkg::ADDR_IRQ_MASK;
  assign pready   = 1'b1;
  assign pslverr  = accessPh & ~addrMapped(paddr);
  assign prdata   = prdata_r;

  // register images as software sees them
  always_comb begin
    ctrlOne = lssef_pkg::REG_RESET;
    ctrlOne[lssef_pkg::C1_SOFT_SHUTDOWN_FLAG] = softShutdown_r;
    ctrlOne[lssef_pkg::C1_PME_BIT]   = pmeBit_r;
    ctrlOne[lssef_pkg::C1_SMI_BIT]   = smiBit_r;
    ctrlOne[lssef_pkg::C1_SCI_BIT]   = sciBit_r;
    ctrlTwo = lssef_pkg::REG_RESET;
    ctrlTwo[lssef_pkg::C2_GATE_A20_MONITOR]  = filt_r[lssef_pkg::PIN_GATE_A20_MONITOR];
    ctrlTwo[lssef_pkg::C2_LPC_RESET_FLAG]  = flag_r[lssef_pkg::EV_LPC_RESET_FLAG];
    ctrlTwo[lssef_pkg::C2_SHUTDOWN_FLAG]  = flag_r[lssef_pkg::EV_SHUTDOWN_FLAG];
    ctrlTwo[lssef_pkg::C2_ABORT_FLAG]  = flag_r[lssef_pkg::EV_ABORT_FLAG];
    ctrlTwo[lssef_pkg::C2_ERROR_INTERRUPT_ENABLE] = error_interrupt_enable_r;
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rdByte = lssef_pkg::REG_RESET;
    if (selOne) begin
      rdByte = ctrlOne;
    end else if (selTwo) begin
      rdByte = ctrlTwo;
    end else if (selZero) begin
      rdByte = ctrlZero_r;
    end else if (selStat) begin
      rdByte = {5'h00, irqStat_r};
    end else if (selMask) begin
      rdByte = {5'h00, irqMask_r};
    end
  end

  // read data is captured in the setup cycle and held through access
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPh && !pwrite) begin
      prdata_r <= {24'h00_0000, rdByte};
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // sideband output bits and own control register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pmeBit_r   <= 1'b0;
      smiBit_r   <= 1'b0;
      sciBit_r   <= 1'b0;
      error_interrupt_enable_r    <= 1'b0;
      ctrlZero_r <= lssef_pkg::REG_RESET;
      irqMask_r  <= lssef_pkg::EV_RESET;
    end else if (wrAcc) begin
      if (selOne) begin
        pmeBit_r <= pwdata[lssef_pkg::C1_PME_BIT];
        smiBit_r <= pwdata[lssef_pkg::C1_SMI_BIT];
        sciBit_r <= pwdata[lssef_pkg::C1_SCI_BIT];
      end
      if (selTwo) begin
        error_interrupt_enable_r <= pwdata[lssef_pkg::C2_ERROR_INTERRUPT_ENABLE];
      end
      if (selZero) begin
        ctrlZero_r <= {3'h0, pwdata[lssef_pkg::C0_USED-1:0]};
      end
      if (selMask) begin
        irqMask_r <= pwdata[lssef_pkg::EV_W-1:0];
      end
    end
  end

  // ****************************************************************
  // soft shutdown
  // ****************************************************************
  logic armZero_r;

  // a read that saw the bit at 0 arms the next write of 1
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      armZero_r <= 1'b0;
    end else if (wrAcc && selOne) begin
      armZero_r <= 1'b0;
    end else if (rdAcc && selOne) begin
      armZero_r <= ~prdata_r[lssef_pkg::C1_SOFT_SHUTDOWN_FLAG];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      softShutdown_r <= 1'b0;
    end else if (lpcReset || hwShutdown) begin
      softShutdown_r <= 1'b0;
    end else if (hwRelease) begin
      softShutdown_r <= 1'b0;
    end else if (wrAcc && selOne) begin
      if (!pwdata[lssef_pkg::C1_SOFT_SHUTDOWN_FLAG]) begin
        softShutdown_r <= 1'b0;
      end else if (armZero_r) begin
        softShutdown_r <= 1'b1;
      end
    end
  end

  assign softShutdown = softShutdown_r;

  // ****************************************************************
  // error flags
  // ****************************************************************
  logic [2:0] armOne_r;
  logic [2:0] swClr;
  logic [2:0] hwClr;

  // a read that saw a flag at 1 arms its clearing write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      armOne_r <= lssef_pkg::EV_RESET;
    end else if (wrAcc && selTwo) begin
      armOne_r <= lssef_pkg::EV_RESET;
    end else if (rdAcc && selTwo) begin
      for (int i = 0; i < lssef_pkg::EV_W; i++) begin
        armOne_r[i] <= armOne_r[i] | prdata_r[flagPos(i)];
      end
    end
  end

  // only a zero written to an armed flag clears it, ones are ignored
  always_comb begin
    for (int i = 0; i < lssef_pkg::EV_W; i++) begin
      swClr[i] = wrAcc & selTwo & armOne_r[i] & ~pwdata[flagPos(i)];
    end
  end

  assign hwClr[lssef_pkg::EV_LPC_RESET_FLAG] = 1'b0;
  assign hwClr[lssef_pkg::EV_SHUTDOWN_FLAG] = lpcReset;
  assign hwClr[lssef_pkg::EV_ABORT_FLAG] = lpcReset | hwShutdown | softShutdown_r;

  // a set arriving with a clear wins
  assign flag_nxt = (flag_r & ~(swClr | hwClr)) | ev;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= lssef_pkg::EV_RESET;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign errorIrq = error_interrupt_enable_r & (|flag_r);

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  // read clears only the bits that read returned
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_r <= lssef_pkg::EV_RESET;
    end else if (rdAcc && selStat) begin
      irqStat_r <= (irqStat_r & ~prdata_r[lssef_pkg::EV_W-1:0]) | ev;
    end else begin
      irqStat_r <= irqStat_r | ev;
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

  // ****************************************************************
  // host sideband pins
  // ****************************************************************
  // open drain: pulled low while bit and enable are both set
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pmeOe <= 1'b0;
      smiOe <= 1'b0;
      sciOe <= 1'b0;
    end else begin
      pmeOe <= pmeBit_r & ctrlZero_r[lssef_pkg::C0_PME_EN];
      smiOe <= smiBit_r & ctrlZero_r[lssef_pkg::C0_SMI_EN];
      sciOe <= sciBit_r & ctrlZero_r[lssef_pkg::C0_SCI_EN];
    end
  end

  assign pmeOut = 1'b0;
  assign smiOut = 1'b0;
  assign sciOut = 1'b0;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence armedOneWrite;
    wrAcc && selOne && pwdata[lssef_pkg::C1_SOFT_SHUTDOWN_FLAG] && armZero_r;
  endsequence

  sequence noShutdownClear;
    !lpcReset && !hwShutdown && !hwRelease;
  endsequence

  sequence ga20Steady;
    $stable(gateA20) [*5];
  endsequence

  a_soft_set_armed: assert property (armedOneWrite and noShutdownClear |=> softShutdown_r)
    else $error("soft shutdown did not set on armed write");
  a_soft_set_unarmed: assert property (
    wrAcc && selOne && !armZero_r && !softShutdown_r |=> !softShutdown_r)
    else $error("soft shutdown set without prior read of zero");
  a_soft_hw_clear: assert property ((lpcReset || hwShutdown) |=> !softShutdown_r)
    else $error("soft shutdown survived reset or shutdown");
  a_soft_release: assert property (hwRelease |=> !softShutdown_r)
    else $error("soft shutdown survived shutdown release");
  a_pme_pin: assert property (
    pmeBit_r && ctrlZero_r[lssef_pkg::C0_PME_EN] ##1 $stable(pmeBit_r) |-> pmeOe)
    else $error("power event pin not driven");
  a_smi_pin: assert property (!smiBit_r |=> !smiOe)
    else $error("management pin driven with bit low");
  a_sci_pin: assert property (!ctrlZero_r[lssef_pkg::C0_SCI_EN] |=> !sciOe)
    else $error("control pin driven while disabled");
  a_gate_a20_monitor_track: assert property (ga20Steady |-> filt_r[lssef_pkg::PIN_GATE_A20_MONITOR] == gateA20)
    else $error("gate a20 monitor does not follow pin");
  a_lpc_reset_flag_set: assert property (ev[lssef_pkg::EV_LPC_RESET_FLAG] |=> flag_r[lssef_pkg::EV_LPC_RESET_FLAG])
    else $error("reset flag not set on edge");
  a_lpc_reset_flag_hold: assert property (
    flag_r[lssef_pkg::EV_LPC_RESET_FLAG] && !swClr[lssef_pkg::EV_LPC_RESET_FLAG] |=> flag_r[lssef_pkg::EV_LPC_RESET_FLAG])
    else $error("reset flag lost without clearing write");
  a_shutdown_flag_set: assert property (ev[lssef_pkg::EV_SHUTDOWN_FLAG] |=> flag_r[lssef_pkg::EV_SHUTDOWN_FLAG])
    else $error("shutdown flag not set on edge");
  a_shutdown_flag_clear: assert property (
    lpcReset && !ev[lssef_pkg::EV_SHUTDOWN_FLAG] |=> !flag_r[lssef_pkg::EV_SHUTDOWN_FLAG])
    else $error("shutdown flag survived reset");
  a_abort_flag_set: assert property (ev[lssef_pkg::EV_ABORT_FLAG] |=> flag_r[lssef_pkg::EV_ABORT_FLAG])
    else $error("abort flag not set");
  a_abort_flag_clear: assert property (
    (lpcReset || hwShutdown || softShutdown_r) && !ev[lssef_pkg::EV_ABORT_FLAG]
    |=> !flag_r[lssef_pkg::EV_ABORT_FLAG])
    else $error("abort flag survived reset or shutdown");
  a_flag_ones_ignored: assert property (
    wrAcc && selTwo && !lpcReset && !hwShutdown && !softShutdown_r && ev == 3'h0
    && pwdata[lssef_pkg::C2_LPC_RESET_FLAG] && pwdata[lssef_pkg::C2_SHUTDOWN_FLAG] && pwdata[lssef_pkg::C2_ABORT_FLAG]
    |=> flag_r == $past(flag_r))
    else $error("write of ones changed a flag");
  a_err_gate: assert property (!error_interrupt_enable_r |-> !errorIrq)
    else $error("error interrupt while disabled");
  a_err_level: assert property ((error_interrupt_enable_r && (|flag_r)) [*2] |-> errorIrq)
    else $error("error interrupt not held");
  a_edge_pulse: assert property (ev[lssef_pkg::EV_LPC_RESET_FLAG] |=> !ev[lssef_pkg::EV_LPC_RESET_FLAG])
    else $error("reset edge pulse longer than one cycle");
  a_stat_rdclr: assert property (
    rdAcc && selStat && prdata_r[lssef_pkg::EV_ABORT_FLAG] && !ev[lssef_pkg::EV_ABORT_FLAG]
    |=> !irqStat_r[lssef_pkg::EV_ABORT_FLAG])
    else $error("status read did not clear bit");

endmodule
`default_nettype wire
